// ===== rtl/fsup_supervisor.sv
// led driver fault supervisor top: start-up check, current limit, overvoltage,
// over-temperature and per-channel disable, with a small register port
// assumes comparator flags and pulses are synchronous to sys_clk
`timescale 1ns/100ps

// Overview of operation
// [RQ1] supply lockout stops switching and resets; operation resumes when supply returns
// [RQ2] switch turned off for the rest of any cycle that exceeds current limit
// [RQ3] start-up injects current into output; no start until switch node above 1.2V
// [RQ4] overvoltage sense rising above then below 20% opens the input protection switch
// [RQ5] lower temperature marks channels below target open; disabled after 6 pwm cycles
// [RQ6] upper temperature stops switching and turns all channel sources off
// [RQ7] after cooling restart at 76% current, reduced further each new event; code stops at LEVEL_MAX, holding 15% from the seventh event on
// [RQ8] channel sense above 4V disabled after 6 pwm cycles, others unaffected
// [RQ9] shorted channel below 4V and no upper over-temperature keeps conducting
// [RQ10] open channel lets output reach overvoltage, then times out after 6 cycles
// [RQ11] overvoltage: channels below target time out after 6 pwm cycles
// [RQ12] zener-open raising output: other channels above 4V switch off after 6 cycles
// [RQ13] regulation follows enabled channels only
// [RQ14] output or switch node short at start-up: permanent shutdown 31ms after power-up
// [RQ15] channel marked good at target; falling below later marks it open
// [RQ16] overvoltage or lower temperature marks all not-good channels open at once
// [RQ17] per-channel timeout counts pwm cycles, clears when fault goes; disable latches
// [RQ18] lockout reset clears channel latches and reduction level, not permanent shutdown
module fsup_supervisor
    import fsup_pkg::*;
#(
    parameter int                  SHORT_DELAY_CYC = SHORT_CYC,
    parameter logic [CNT_W-1:0]    TIMEOUT_PWM     = CNT_W'(CHAN_TIMEOUT)
) (
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    // register port
    input  wire logic [ADDR_W-1:0]    reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [31:0]          reg_rdata,
    // analog comparators and timing pulses
    input  wire logic                 supply_lockout,
    input  wire logic                 switch_cycle_start,
    input  wire logic                 switch_over_limit,
    input  wire logic                 boost_switch_node_ok,
    input  wire logic                 output_overvoltage_sense_above,
    input  wire logic                 overvoltage_threshold_hit,
    input  wire logic                 temp_lower_hit,
    input  wire logic                 temp_upper_hit,
    input  wire logic                 temp_cooled,
    input  wire logic                 pwm_cycle_start,
    input  wire logic [NUM_CHAN-1:0]  channel_at_target,
    input  wire logic [NUM_CHAN-1:0]  channel_sense_node_high,
    // power stage controls
    output logic                      boost_switch_enable,
    output logic                      startup_source_enable,
    output logic                      input_switch_on,
    output logic                      shutdown_latched,
    output logic [NUM_CHAN-1:0]       channel_enable,
    output logic [NUM_CHAN-1:0]       regulation_select,
    output logic [6:0]                current_scale_pct
);

    typedef struct packed {
        fsup_state_type       st;
        logic [TMR_W-1:0]     tmr;
        logic                 tmr_done;
        logic                 lim_hit;
        logic                 ovp_armed;
        logic                 dead;
        logic [2:0]           level;
        logic [NUM_CHAN-1:0]  mask;
        logic [31:0]          rdata;
    } fsup_top_state_type;

    localparam fsup_top_state_type TOP_RST = '{st: ST_CHECK, tmr: '0, tmr_done: 1'b0, lim_hit: 1'b0,
                                              ovp_armed: 1'b0, dead: 1'b0, level: 3'h0,
                                              mask: CTRL_MASK_RST, rdata: 32'h0};
    localparam logic [TMR_W-1:0] SHORT_LAST = TMR_W'(SHORT_DELAY_CYC - 1);

    fsup_top_state_type   s_r;
    fsup_top_state_type   s_nxt;
    logic [NUM_CHAN-1:0]  ch_good;
    logic [NUM_CHAN-1:0]  ch_open;
    logic [NUM_CHAN-1:0]  ch_dis;
    logic [NUM_CHAN-1:0]  ch_on;
    logic                 running;

    fsup_chan_if ch_if [NUM_CHAN] ();

    // percentage of nominal current for a reduction level
    function automatic logic [6:0] pct_of_level(input logic [2:0] lvl);
        pct_of_level = PCT_TABLE[lvl];
    endfunction

    assign running = (s_r.st == ST_RUN) && !supply_lockout;

    // one monitor per channel
    generate
        for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
            assign ch_if[i].pwm_tick   = pwm_cycle_start;
            assign ch_if[i].clear      = supply_lockout;                              // see [RQ18]
            assign ch_if[i].mark_all   = overvoltage_threshold_hit || temp_lower_hit;  // see [RQ16]
            assign ch_if[i].run        = running;
            assign ch_if[i].allow      = s_r.mask[i];
            assign ch_if[i].at_target  = channel_at_target[i];
            assign ch_if[i].sense_high = channel_sense_node_high[i];
            assign ch_good[i]          = ch_if[i].good;
            assign ch_open[i]          = ch_if[i].open;
            assign ch_dis[i]           = ch_if[i].disabled;
            assign ch_on[i]            = ch_if[i].chan_on;

            fsup_chan_mon #(
                .TIMEOUT (TIMEOUT_PWM)
            ) u_mon (
                .sys_clk (sys_clk),
                .reset   (reset),
                .ch      (ch_if[i])
            );
        end
    endgenerate

    // supervisor next state
    always_comb begin
        s_nxt = s_r;
        // power-up timer runs once from reset release
        if (!s_r.tmr_done) begin
            if (s_r.tmr == SHORT_LAST) begin
                s_nxt.tmr_done = 1'b1;
            end else begin
                s_nxt.tmr = s_r.tmr + TMR_W'(1);
            end
        end
        // cycle-by-cycle current limit, a new over-limit wins over the cycle restart
        if (switch_over_limit) begin
            s_nxt.lim_hit = 1'b1;                                    // see [RQ2]
        end else if (switch_cycle_start) begin
            s_nxt.lim_hit = 1'b0;
        end
        if (supply_lockout && s_r.st != ST_DEAD) begin
            s_nxt.st        = ST_CHECK;                              // see [RQ1]
            s_nxt.lim_hit   = 1'b0;
            s_nxt.ovp_armed = 1'b0;
            s_nxt.level     = 3'h0;                                  // see [RQ18]
        end else begin
            unique case (s_r.st)
                ST_CHECK: begin
                    if (boost_switch_node_ok) begin
                        s_nxt.st = ST_RUN;                           // see [RQ3]
                    end else if (s_r.tmr_done) begin
                        s_nxt.st   = ST_DEAD;                        // see [RQ14]
                        s_nxt.dead = 1'b1;
                    end
                end
                ST_RUN: begin
                    if (output_overvoltage_sense_above) begin
                        s_nxt.ovp_armed = 1'b1;
                    end
                    if (s_r.ovp_armed && !output_overvoltage_sense_above) begin
                        s_nxt.st   = ST_DEAD;                        // see [RQ4]
                        s_nxt.dead = 1'b1;
                    end else if (temp_upper_hit) begin
                        s_nxt.st = ST_HOT;                           // see [RQ6]
                        if (s_r.level != LEVEL_MAX) begin
                            s_nxt.level = s_r.level + 3'h1;          // see [RQ7]
                        end
                    end
                end
                ST_HOT: begin
                    s_nxt.ovp_armed = 1'b0;
                    if (temp_cooled && !temp_upper_hit) begin
                        s_nxt.st = ST_RUN;                           // see [RQ7]
                    end
                end
                ST_DEAD: begin
                    s_nxt.dead = 1'b1;
                end
            endcase
        end
        // register writes
        if (reg_wr && reg_addr == REG_CTRL_ADDR) begin
            s_nxt.mask = reg_wdata[CTRL_MASK_LSB +: NUM_CHAN];
        end
        // register reads, answer in the next cycle only
        s_nxt.rdata = 32'h0;
        if (reg_rd) begin
            unique case (reg_addr)
                REG_CTRL_ADDR: begin
                    s_nxt.rdata[CTRL_MASK_LSB +: NUM_CHAN] = s_r.mask;
                end
                REG_STATUS_ADDR: begin
                    s_nxt.rdata[STAT_STATE_LSB +: 2] = s_r.st;
                    s_nxt.rdata[STAT_DEAD_BIT]       = s_r.dead;
                    s_nxt.rdata[STAT_LEVEL_LSB +: 3] = s_r.level;
                    s_nxt.rdata[STAT_PCT_LSB +: 7]   = pct_of_level(s_r.level);
                end
                REG_CHAN_ADDR: begin
                    s_nxt.rdata[CHAN_DIS_LSB +: NUM_CHAN]  = ch_dis;
                    s_nxt.rdata[CHAN_GOOD_LSB +: NUM_CHAN] = ch_good;
                    s_nxt.rdata[CHAN_OPEN_LSB +: NUM_CHAN] = ch_open;
                    s_nxt.rdata[CHAN_ON_LSB +: NUM_CHAN]   = ch_on;
                end
                default: begin
                    s_nxt.rdata = 32'h0;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_r <= TOP_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // power stage outputs
    assign boost_switch_enable   = running && !s_r.lim_hit;                                  // see [RQ2] [RQ6]
    assign startup_source_enable = (s_r.st == ST_CHECK) && !supply_lockout && !s_r.dead;     // see [RQ3]
    assign input_switch_on       = !s_r.dead;                                                // see [RQ4] [RQ14]
    assign shutdown_latched      = s_r.dead;
    assign channel_enable        = ch_on;                                                    // see [RQ6] [RQ8]
    assign regulation_select     = ch_on;                                                    // see [RQ13]
    assign current_scale_pct     = pct_of_level(s_r.level);                                  // see [RQ7]
    assign reg_rdata             = s_r.rdata;

endmodule

// ===== rtl/fsup_pkg.sv
// fault supervisor package: register map, field layout, reset values, timing counts
// assumes a single 100 MHz clock and a plain strobe-based register port
package fsup_pkg;

    // clock rate and derived timing
    localparam int CLK_KHZ         = 100000;              // 100 MHz system clock
    localparam int SHORT_TIME_MS   = 31;                  // start-up short shutdown delay in ms
    localparam int SHORT_CYC       = SHORT_TIME_MS * CLK_KHZ;
    localparam int TMR_W           = 23;                  // wide enough for the start-up delay
    localparam int CHAN_TIMEOUT    = 6;                   // dimming pwm cycles before disable
    localparam int CNT_W           = 3;
    localparam int NUM_CHAN        = 4;

    // register port
    localparam int ADDR_W          = 4;
    localparam logic [3:0] REG_CTRL_ADDR   = 4'h0;        // channel enable mask
    localparam logic [3:0] REG_STATUS_ADDR = 4'h4;        // supervisor state
    localparam logic [3:0] REG_CHAN_ADDR   = 4'h8;        // per-channel flags

    // field positions
    localparam int CTRL_MASK_LSB   = 0;
    localparam int STAT_STATE_LSB  = 0;                   // 2 bits
    localparam int STAT_DEAD_BIT   = 2;
    localparam int STAT_LEVEL_LSB  = 4;                   // 3 bits
    localparam int STAT_PCT_LSB    = 8;                   // 7 bits
    localparam int CHAN_DIS_LSB    = 0;
    localparam int CHAN_GOOD_LSB   = 4;
    localparam int CHAN_OPEN_LSB   = 8;
    localparam int CHAN_ON_LSB     = 12;

    // reset values
    localparam logic [3:0] CTRL_MASK_RST = 4'hf;

    // current reduction: 76% per upper over-temperature event, held at 15% from level 7 (LEVEL_MAX) on
    localparam logic [2:0] LEVEL_MAX = 3'h7;
    localparam logic [6:0] PCT_TABLE [0:7] = '{7'h64, 7'h4c, 7'h3a, 7'h2c, 7'h21, 7'h19, 7'h13, 7'h0f};

    typedef enum logic [1:0] {
        ST_CHECK = 2'b00,       // start-up node check, current injected, no switching
        ST_RUN   = 2'b01,       // normal switching
        ST_HOT   = 2'b10,       // upper over-temperature, switching and channels off, input switch stays on
        ST_DEAD  = 2'b11        // permanent shutdown
    } fsup_state_type;

endpackage

// ===== rtl/fsup_chan_if.sv
// signals between the supervisor and one channel monitor
// assumes both ends share sys_clk
`timescale 1ns/100ps
interface fsup_chan_if;
    logic pwm_tick;     // dimming pwm cycle boundary pulse
    logic clear;        // lockout reset of the channel latches
    logic mark_all;     // overvoltage or lower over-temperature reached
    logic run;          // supervisor is switching
    logic allow;        // software mask bit
    logic at_target;    // channel current at regulation target
    logic sense_high;   // channel sense node above short threshold
    logic good;
    logic open;
    logic disabled;
    logic chan_on;

    modport sup (output pwm_tick, clear, mark_all, run, allow, at_target, sense_high,
                 input good, open, disabled, chan_on);
    modport mon (input pwm_tick, clear, mark_all, run, allow, at_target, sense_high,
                 output good, open, disabled, chan_on);
endinterface

// ===== rtl/fsup_chan_mon.sv
// one channel monitor: good/open marking, timeout counter, disable latch
// assumes comparator inputs are synchronous and qualified by the partner
`timescale 1ns/100ps
module fsup_chan_mon
    import fsup_pkg::*;
#(
    parameter logic [CNT_W-1:0] TIMEOUT = CNT_W'(CHAN_TIMEOUT)
) (
    // clock and reset
    input  wire logic  sys_clk,
    input  wire logic  reset,
    // link to the supervisor
    fsup_chan_if.mon   ch
);

    typedef struct packed {
        logic             good;
        logic             open;
        logic             disabled;
        logic [CNT_W-1:0] cnt;
    } fsup_chan_state_type;

    fsup_chan_state_type s_r;
    fsup_chan_state_type s_nxt;
    logic                fault;

    // next state of the channel
    always_comb begin
        s_nxt = s_r;
        fault = s_r.open || ch.sense_high;
        if (ch.clear) begin
            s_nxt = '0;                                    // see [RQ18]
        end else if (ch.run && !s_r.disabled) begin
            if (ch.at_target) begin
                s_nxt.good = 1'b1;                         // see [RQ15]
                s_nxt.open = 1'b0;
            end else if (s_r.good || ch.mark_all) begin
                s_nxt.good = 1'b0;                         // see [RQ15] [RQ16]
                s_nxt.open = 1'b1;                         // see [RQ5] [RQ10] [RQ11]
            end
            if (!fault) begin
                s_nxt.cnt = '0;                            // see [RQ17]
            end else if (ch.pwm_tick) begin
                s_nxt.cnt = s_r.cnt + CNT_W'(1);           // see [RQ8] [RQ12]
                if (s_nxt.cnt >= TIMEOUT) begin
                    s_nxt.disabled = 1'b1;                 // see [RQ17]
                end
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // a short below the threshold keeps conducting
    assign ch.chan_on  = ch.run && ch.allow && !s_r.disabled;   // see [RQ9]
    assign ch.good     = s_r.good;
    assign ch.open     = s_r.open;
    assign ch.disabled = s_r.disabled;

endmodule

// ===== test/fsup_monitor.sv
// checker for the fault supervisor top ports
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/100ps
module fsup_monitor import fsup_pkg::*; (
    // clock and reset
    input wire logic                sys_clk,
    input wire logic                reset,
    // comparator inputs
    input wire logic                supply_lockout,
    input wire logic                switch_over_limit,
    input wire logic                boost_switch_node_ok,
    input wire logic                temp_upper_hit,
    // power stage outputs
    input wire logic                boost_switch_enable,
    input wire logic                startup_source_enable,
    input wire logic                input_switch_on,
    input wire logic                shutdown_latched,
    input wire logic [NUM_CHAN-1:0] channel_enable,
    input wire logic [NUM_CHAN-1:0] regulation_select,
    input wire logic [6:0]          current_scale_pct
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // lockout, current limit and start-up check
    lockout_stop_a: assert property (
        supply_lockout |-> !boost_switch_enable && channel_enable == 4'h0)
        else $error("switching during lockout");
    lockout_resume_a: assert property (
        $fell(supply_lockout) && !shutdown_latched |-> startup_source_enable)
        else $error("no restart after lockout");
    limit_off_a: assert property (switch_over_limit |=> !boost_switch_enable)
        else $error("switch on after over-limit");
    check_hold_a: assert property (
        startup_source_enable && !boost_switch_node_ok |=> !boost_switch_enable)
        else $error("switching before node ok");
    check_leave_a: assert property (
        startup_source_enable && boost_switch_node_ok |=> !startup_source_enable)
        else $error("start-up check not left");
    // permanent shutdown
    dead_off_a: assert property (
        shutdown_latched |-> !input_switch_on && !boost_switch_enable && channel_enable == 4'h0)
        else $error("activity in shutdown");
    dead_hold_a: assert property (shutdown_latched |=> shutdown_latched)
        else $error("shutdown latch lost");
    // over-temperature and regulation select
    hot_off_a: assert property (
        channel_enable != 4'h0 && temp_upper_hit |=> channel_enable == 4'h0 && !boost_switch_enable)
        else $error("no hot shutdown");
    hot_reduce_a: assert property (
        channel_enable != 4'h0 && temp_upper_hit && current_scale_pct == 7'h64 |=> current_scale_pct == 7'h4c)
        else $error("current not reduced");
    hot_hold_a: assert property (
        channel_enable == 4'h0 && temp_upper_hit && !startup_source_enable |=> channel_enable == 4'h0)
        else $error("channels on while hot");
    reg_select_a: assert property (regulation_select == channel_enable)
        else $error("regulation uses disabled channel");
endmodule
bind fsup_supervisor fsup_monitor fsup_monitor_inst (.sys_clk, .reset, .supply_lockout, .switch_over_limit,
    .boost_switch_node_ok, .temp_upper_hit, .boost_switch_enable, .startup_source_enable, .input_switch_on,
    .shutdown_latched, .channel_enable, .regulation_select, .current_scale_pct);

// ===== test/fsup_partner.sv
// far side model: boost cycle and dimming pulses, switch node comparator
// assumes the start-up source charges the node in CHARGE cycles unless shorted
`timescale 1ns/100ps
module fsup_partner #(
    parameter int SW_PER  = 4,
    parameter int PWM_PER = 8,
    parameter int CHARGE  = 10
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic reset,
    // supervisor and bench
    input  wire logic startup_source_enable,
    input  wire logic node_shorted,
    // pulses and comparator
    output logic      switch_cycle_start,
    output logic      pwm_cycle_start,
    output logic      boost_switch_node_ok
);
    int cyc = 0;
    int chg = 0;
    // cycle counter and node charge, a short holds the node low
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (reset || node_shorted) chg <= 0;
        else if (startup_source_enable && chg < CHARGE) chg <= chg + 1;
    end
    // one-cycle pulses and the node comparator
    assign switch_cycle_start   = (cyc % SW_PER) == 0;
    assign pwm_cycle_start      = (cyc % PWM_PER) == 0;
    assign boost_switch_node_ok = (chg >= CHARGE) && !node_shorted;
endmodule

// ===== test/testbench.sv
// self-checking bench for the led driver fault supervisor
// assumes fsup_partner makes the pulses and the switch node comparator
`timescale 1ns/100ps
module testbench import fsup_pkg::*;;
    logic       sys_clk = 1'h0, reset = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, node_shorted = 1'h0;
    logic       supply_lockout = 1'h0, switch_over_limit = 1'h0, output_overvoltage_sense_above = 1'h0;
    logic       overvoltage_threshold_hit = 1'h0, temp_lower_hit = 1'h0, temp_upper_hit = 1'h0, temp_cooled = 1'h0;
    logic       switch_cycle_start, pwm_cycle_start, boost_switch_node_ok, boost_switch_enable;
    logic       startup_source_enable, input_switch_on, shutdown_latched;
    logic [3:0] reg_addr = 4'h0, channel_at_target = 4'hf, channel_sense_node_high = 4'h0;
    logic [3:0] channel_enable, regulation_select, faults, kinds;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_val;
    logic [6:0] current_scale_pct;
    int         seed = 32'h41a0ceaf, err_total = 0, comparisons = 0;

    fsup_supervisor #(.SHORT_DELAY_CYC(200)) fsup_supervisor_inst (.sys_clk, .reset, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .supply_lockout, .switch_cycle_start, .switch_over_limit,
        .boost_switch_node_ok, .output_overvoltage_sense_above, .overvoltage_threshold_hit, .temp_lower_hit,
        .temp_upper_hit, .temp_cooled, .pwm_cycle_start, .channel_at_target, .channel_sense_node_high,
        .boost_switch_enable, .startup_source_enable, .input_switch_on, .shutdown_latched, .channel_enable,
        .regulation_select, .current_scale_pct);
    fsup_partner fsup_partner_inst (.sys_clk, .reset, .startup_source_enable, .node_shorted,
        .switch_cycle_start, .pwm_cycle_start, .boost_switch_node_ok);

    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    // compare, count and report
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // register port cycles
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        tick(1);
        reg_wr <= 1'h0;
        tick(1);
    endtask
    task automatic rd(input logic [3:0] a);
        reg_addr <= a;
        reg_rd <= 1'h1;
        tick(1);
        reg_rd <= 1'h0;
        tick(1);
        rd_val = reg_rdata;
    endtask
    // bounded wait for n pwm ticks, or for switching to run
    task automatic wait_for(input logic run, input int n);
        int k;
        repeat (n) begin
            k = 0;
            do begin
                tick(1);
                k++;
            end while (!(run ? boost_switch_enable : pwm_cycle_start) && k < 40);
            if (k >= 40) begin
                err_total++;
                end_sim;
            end
        end
    endtask
    task automatic lockout(input logic resume);
        supply_lockout <= 1'h1;
        tick(3);
        supply_lockout <= 1'h0;
        tick(1);
        if (resume) wait_for(1'h1, 1);
    endtask
    // expected values
    function automatic logic [6:0] exp_pct(input int n);
        int p = 100;
        repeat (n) p = (p * 76 + 50) / 100;
        return 7'(p);
    endfunction
    function automatic logic [3:0] exp_en(input logic [3:0] f);
        return 4'hf & ~f;
    endfunction

    // hang guard
    initial begin
        tick(50000);
        err_total++;
        end_sim;
    end

    // main sequence
    initial begin
        tick(16);
        reset <= 1'h0;
        tick(1);
        chk(startup_source_enable, 1'h1);
        chk(current_scale_pct, 7'h64);
        rd(REG_CTRL_ADDR);
        chk(rd_val, 32'hf);
        wr(4'hc, 32'h5);
        rd(4'hc);
        chk(rd_val, 32'h0);
        wait_for(1'h1, 1);
        wr(REG_CTRL_ADDR, 32'h7);
        chk(regulation_select, 4'h7);
        wr(REG_CTRL_ADDR, 32'hf);
        switch_over_limit <= 1'h1;
        tick(1);
        switch_over_limit <= 1'h0;
        tick(1);
        chk(boost_switch_enable, 1'h0);
        wait_for(1'h1, 1);
        // random channel faults, open or shorted, then counter clearing on channel 3
        for (int r = 0; r < 4; r++) begin
            faults = (r == 3) ? 4'h8 : 4'($random(seed));
            kinds = 4'($random(seed));
            wait_for(1'h0, 1);
            channel_at_target <= 4'hf ^ (faults & kinds);
            channel_sense_node_high <= faults & ~kinds;
            if (r == 3) begin
                // fault goes away for two cycles, open or short alike
                wait_for(1'h0, 4);
                channel_at_target <= 4'hf;
                channel_sense_node_high <= 4'h0;
                tick(2);
                channel_at_target <= 4'hf ^ (faults & kinds);
                channel_sense_node_high <= faults & ~kinds;
            end
            wait_for(1'h0, 5);
            tick(3);
            chk(channel_enable, 4'hf);
            wait_for(1'h0, 1);
            tick(3);
            chk(channel_enable, exp_en(faults));
            rd(REG_CHAN_ADDR);
            chk(rd_val[CHAN_DIS_LSB +: 4], faults);
            channel_at_target <= 4'hf;
            channel_sense_node_high <= 4'h0;
            lockout(1'h1);
            chk(channel_enable, 4'hf);
        end
        // channel 0 never good, marked open by lower temperature or overvoltage
        for (int c = 0; c < 2; c++) begin
            channel_at_target <= 4'he;
            lockout(1'h1);
            wait_for(1'h0, 7);
            chk(channel_enable, 4'hf);
            temp_lower_hit <= (c == 0);
            overvoltage_threshold_hit <= (c == 1);
            tick(1);
            temp_lower_hit <= 1'h0;
            overvoltage_threshold_hit <= 1'h0;
            wait_for(1'h0, 6);
            tick(3);
            chk(channel_enable, 4'he);
        end
        channel_at_target <= 4'hf;
        lockout(1'h1);
        // upper temperature events and current reduction
        for (int k = 1; k < 3; k++) begin
            temp_upper_hit <= 1'h1;
            tick(2);
            chk(channel_enable, 4'h0);
            chk(current_scale_pct, exp_pct(k));
            rd(REG_STATUS_ADDR);
            chk(rd_val[STAT_LEVEL_LSB +: 3], 3'(k));
            temp_upper_hit <= 1'h0;
            temp_cooled <= 1'h1;
            wait_for(1'h1, 1);
            temp_cooled <= 1'h0;
            chk(channel_enable, 4'hf);
        end
        lockout(1'h1);
        chk(current_scale_pct, 7'h64);
        // overvoltage sense dip, then a start-up short
        output_overvoltage_sense_above <= 1'h1;
        tick(3);
        output_overvoltage_sense_above <= 1'h0;
        tick(3);
        chk(input_switch_on, 1'h0);
        lockout(1'h0);
        chk(shutdown_latched, 1'h1);
        node_shorted <= 1'h1;
        reset <= 1'h1;
        tick(16);
        reset <= 1'h0;
        tick(190);
        chk(shutdown_latched, 1'h0);
        tick(20);
        chk(shutdown_latched, 1'h1);
        end_sim;
    end
endmodule
